// ---- rtl/fsp_pkg.sv ----
// Constants for the sector protection command logic of a serial flash.
// Assumes a 25 MHz core clock and a single-wire serial link.
package fsp_pkg;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WR_EN = 8'h06;
	localparam logic [7:0] OP_WR_DIS = 8'h04;
	localparam logic [7:0] OP_STAT_RD = 8'h05;
	localparam logic [7:0] OP_VOL_WR = 8'hfb;
	localparam logic [7:0] OP_VOL_WR_LONG = 8'he1;
	localparam logic [7:0] OP_PERS_RD = 8'hfc;
	localparam logic [7:0] OP_PERS_RD_LONG = 8'he2;
	localparam logic [7:0] OP_PERS_PG = 8'hfd;
	localparam logic [7:0] OP_PERS_PG_LONG = 8'he3;
	localparam logic [7:0] OP_PERS_ER = 8'he4;
	localparam logic [7:0] OP_CFG_RD = 8'h2b;
	localparam logic [7:0] OP_CFG_PG = 8'h2f;
	localparam logic [7:0] OP_LOCK_RD = 8'ha7;
	localparam logic [7:0] OP_LOCK_CLR = 8'ha6;
	localparam logic [7:0] OP_FREEZE = 8'h91;

	// ----------------------------------------------------------------
	// Frame lengths in bits
	// ----------------------------------------------------------------
	localparam logic [6:0] OPC_BITS = 7'h08;
	localparam logic [6:0] ADDR3_BITS = 7'h18;
	localparam logic [6:0] ADDR4_BITS = 7'h20;
	localparam logic [6:0] BYTE_BITS = 7'h08;
	localparam logic [6:0] CFG_BITS = 7'h10;
	localparam logic [6:0] CNT_SAT = 7'h7e;

	// ----------------------------------------------------------------
	// Field positions and sizes
	// ----------------------------------------------------------------
	localparam int SECTORS = 64;
	localparam int SECT_W = 6;
	localparam int SECT_LSB = 16;
	localparam int EXT_ADDR_BIT = 7;
	localparam int LOCK_BIT = 0;
	localparam int FREEZE_BIT = 7;
	localparam int STAT_WIP_BIT = 0;
	localparam int STAT_WEL_BIT = 1;

	// ----------------------------------------------------------------
	// Reset and access values
	// ----------------------------------------------------------------
	localparam logic [15:0] CFG_RESET = 16'hffff;
	localparam logic [7:0] LOCK_RESET = 8'h01;
	localparam logic [63:0] PROT_RESET = 64'hffffffffffffffff;
	localparam logic [7:0] ACCESS_OPEN = 8'hff;
	localparam logic [7:0] ACCESS_SHUT = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int OP_TIME_NS = 1000;
	localparam int ERASE_TIME_NS = 2000;
	localparam int OP_CYCLES = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int ERASE_CYCLES = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} fsp_state_e;
	typedef enum logic [5:0] {
		JOB_VOL = 6'b000001,
		JOB_PG = 6'b000010,
		JOB_ER = 6'b000100,
		JOB_CFG = 6'b001000,
		JOB_LOCK = 6'b010000,
		JOB_FRZ = 6'b100000
	} fsp_job_e;

endpackage

// ---- rtl/fsp_protect_cmds.sv ----
// Sector protection command interpreter: serial front end plus protection state.
// Assumes the host holds the serial clock still while chip select is high.
//
// Contract
// - Volatile bit write runs only if the write enable latch is set.
// - FBh takes 3 or 4 address bytes by extended bit; E1h always 4.
// - Volatile write: opcode, address, one byte, select rises after it, then runs.
// - Persistent read shifts out its 8-bit access byte, single-wire mode only.
// - Persistent read repeats the same byte every eight clocks, no increment.
// - FCh takes 3 or 4 address bytes by extended bit; E2h always 4.
// - FDh takes 3 or 4 address bytes by extended bit; E3h always 4.
// - Persistent program starts at select rise after address; busy, then clears latch.
// - Status stays readable while any protection operation is busy.
// - Persistent erase with latch set makes every persistent bit one.
// - Erase needs select rise after eight bits; busy meanwhile; latch cleared.
// - Config read sends 16 bits, low byte first, MSB first, repeating.
// - Config program takes exactly two bytes, low first; busy, then latch cleared.
// - Lock read repeats every eight bits, valid only when idle.
// - Lock clear command with latch set clears the lock bit.
// - Lock clear needs exactly eight bits; busy meanwhile; latch cleared after.
// - Freeze command with latch set sets bit 7 of the lock register.
// - Freeze needs exactly eight bits; busy meanwhile; latch cleared after.
// - Extended address select is bit 7 of the bank address register.
`timescale 1ns/1ns
module fsp_protect_cmds
	import fsp_pkg::*;
(
	// Core clock and reset
	input wire logic clock,
	input wire logic srst,
	// Serial link
	input wire logic sck,
	input wire logic csN,
	input wire logic si,
	output logic so,
	output logic soOe,
	// Mode inputs
	input wire logic [7:0] bankAddr,
	input wire logic quadWideCmdMode,
	// Protection state
	output logic [fsp_pkg::SECTORS-1:0] volatileProtectBit,
	output logic [fsp_pkg::SECTORS-1:0] persistentProtectBit,
	output logic [15:0] protectConfigRegister,
	output logic [7:0] protectLockRegister,
	output logic writeEnableLatch,
	output logic writeInProgress
);
	import fsp_pkg::*;

	localparam int BusyCycles = OP_CYCLES;
	localparam int EraseCycles = ERASE_CYCLES;

	// ----------------------------------------------------------------
	// Link side: bit capture on rising edges
	// ----------------------------------------------------------------
	logic [6:0] bitCnt_q;
	logic [6:0] nextCnt;
	logic [31:0] sr_q;
	logic [7:0] opL_q;
	logic [31:0] addrL_q;
	logic good_q;
	logic [7:0] curOp;
	logic extMeta_q, extSync_q;
	logic quadMeta_q, quadSync_q;
	logic wipMeta_q, wipSync_q;
	logic welMeta_q, welSync_q;
	logic [15:0] cfgMeta_q, cfgSync_q;
	logic [7:0] lockMeta_q, lockSync_q;
	logic [SECTORS-1:0] ppbMeta_q, ppbSync_q;

	function automatic logic [6:0] addrEnd(input logic [7:0] op, input logic ext);
		logic isLong;
		isLong = ext || op == OP_VOL_WR_LONG || op == OP_PERS_RD_LONG || op == OP_PERS_PG_LONG;
		addrEnd = OPC_BITS + (isLong ? ADDR4_BITS : ADDR3_BITS);
	endfunction

	function automatic logic [6:0] needBits(input logic [7:0] op, input logic ext);
		needBits = 7'h00;
		case (op)
			OP_WR_EN, OP_WR_DIS, OP_PERS_ER, OP_LOCK_CLR, OP_FREEZE: needBits = OPC_BITS;
			OP_VOL_WR, OP_VOL_WR_LONG: needBits = addrEnd(op, ext) + BYTE_BITS;
			OP_PERS_PG, OP_PERS_PG_LONG: needBits = addrEnd(op, ext);
			OP_CFG_PG: needBits = OPC_BITS + CFG_BITS;
			default: needBits = 7'h00;
		endcase
	endfunction

	assign nextCnt = bitCnt_q + 7'h01;
	assign curOp = (bitCnt_q == OPC_BITS - 7'h01) ? {sr_q[6:0], si} : opL_q;

	always_ff @(posedge sck or posedge csN) begin
		if (csN) begin
			bitCnt_q <= 7'h00;
		end else if (bitCnt_q != CNT_SAT) begin
			bitCnt_q <= nextCnt;
		end
	end

	// Kept across the select rise so the core can read them afterwards
	always_ff @(posedge sck) begin
		sr_q <= {sr_q[30:0], si};
		if (bitCnt_q == OPC_BITS - 7'h01) begin
			opL_q <= {sr_q[6:0], si};
		end
		if (nextCnt == addrEnd(curOp, extSync_q)) begin
			addrL_q <= {sr_q[30:0], si};
		end
		good_q <= (nextCnt == needBits(curOp, extSync_q));
	end

	// Slow-moving core values: they only change between frames
	always_ff @(posedge sck) begin
		extMeta_q <= bankAddr[EXT_ADDR_BIT];
		extSync_q <= extMeta_q;
		quadMeta_q <= quadWideCmdMode;
		quadSync_q <= quadMeta_q;
		wipMeta_q <= writeInProgress;
		wipSync_q <= wipMeta_q;
		welMeta_q <= writeEnableLatch;
		welSync_q <= welMeta_q;
		cfgMeta_q <= protectConfigRegister;
		cfgSync_q <= cfgMeta_q;
		lockMeta_q <= protectLockRegister;
		lockSync_q <= lockMeta_q;
		ppbMeta_q <= persistentProtectBit;
		ppbSync_q <= ppbMeta_q;
	end

	// ----------------------------------------------------------------
	// Link side: read data on falling edges
	// ----------------------------------------------------------------
	logic [3:0] rdCnt_q;
	logic [6:0] hdrLen;
	logic readable;
	logic txBit;
	logic [7:0] accessByte;
	logic [2:0] bitIdx;

	assign bitIdx = ~rdCnt_q[2:0];
	assign accessByte = ppbSync_q[addrL_q[SECT_LSB +: SECT_W]] ? ACCESS_OPEN : ACCESS_SHUT;

	always_comb begin
		hdrLen = OPC_BITS;
		readable = 1'b0;
		txBit = 1'b0;
		case (opL_q)
			OP_STAT_RD: begin
				readable = 1'b1;
				txBit = (bitIdx == 3'(STAT_WIP_BIT)) ? wipSync_q : (bitIdx == 3'(STAT_WEL_BIT)) && welSync_q;
			end
			OP_CFG_RD: begin
				readable = 1'b1;
				txBit = cfgSync_q[{rdCnt_q[3], bitIdx}];
			end
			OP_LOCK_RD: begin
				readable = !wipSync_q;
				txBit = lockSync_q[bitIdx];
			end
			OP_PERS_RD, OP_PERS_RD_LONG: begin
				hdrLen = addrEnd(opL_q, extSync_q);
				readable = !quadSync_q;
				txBit = accessByte[bitIdx];
			end
			default: begin
				readable = 1'b0;
			end
		endcase
	end

	always_ff @(negedge sck or posedge csN) begin
		if (csN) begin
			rdCnt_q <= 4'h0;
			so <= 1'b0;
			soOe <= 1'b0;
		end else if (readable && bitCnt_q >= hdrLen) begin
			so <= txBit;
			soOe <= 1'b1;
			rdCnt_q <= rdCnt_q + 4'h1;
		end else begin
			soOe <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Core side: frame end detection
	// ----------------------------------------------------------------
	logic csMeta_q, csSync_q, csPrev_q;
	logic frameEnd;

	always_ff @(posedge clock) begin
		if (srst) begin
			csMeta_q <= 1'b1;
			csSync_q <= 1'b1;
			csPrev_q <= 1'b1;
		end else begin
			csMeta_q <= csN;
			csSync_q <= csMeta_q;
			csPrev_q <= csSync_q;
		end
	end

	assign frameEnd = csSync_q && !csPrev_q;

	// ----------------------------------------------------------------
	// Core side: command decode and busy sequencing
	// ----------------------------------------------------------------
	fsp_state_e state_q;
	fsp_job_e job_q, jobD;
	logic [7:0] busyCnt_q;
	logic [SECT_W-1:0] jobSect_q;
	logic [15:0] jobData_q;
	logic needsWel;
	logic accept;
	logic done;

	always_comb begin
		needsWel = 1'b1;
		jobD = JOB_VOL;
		case (opL_q)
			OP_VOL_WR, OP_VOL_WR_LONG: jobD = JOB_VOL;
			OP_PERS_PG, OP_PERS_PG_LONG: jobD = JOB_PG;
			OP_PERS_ER: jobD = JOB_ER;
			OP_CFG_PG: jobD = JOB_CFG;
			OP_LOCK_CLR: jobD = JOB_LOCK;
			OP_FREEZE: jobD = JOB_FRZ;
			default: needsWel = 1'b0;
		endcase
	end

	// Link registers are still here: no clock edges since select rose
	assign accept = frameEnd && state_q == ST_IDLE && good_q && needsWel && writeEnableLatch;
	assign done = state_q == ST_BUSY && busyCnt_q == 8'h01;
	assign writeInProgress = state_q == ST_BUSY;

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= ST_IDLE;
			busyCnt_q <= 8'h00;
			job_q <= JOB_VOL;
			jobSect_q <= '0;
			jobData_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (accept) begin
						state_q <= ST_BUSY;
						busyCnt_q <= (jobD == JOB_ER) ? 8'(ERASE_CYCLES) : 8'(OP_CYCLES);
						job_q <= jobD;
						jobSect_q <= addrL_q[SECT_LSB +: SECT_W];
						jobData_q <= sr_q[15:0];
					end
				end
				ST_BUSY: begin
					busyCnt_q <= busyCnt_q - 8'h01;
					if (done) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Erase has no suspend path: nothing can leave the busy state early
	always_ff @(posedge clock) begin
		if (srst) begin
			writeEnableLatch <= 1'b0;
		end else if (done) begin
			writeEnableLatch <= 1'b0;
		end else if (frameEnd && state_q == ST_IDLE && good_q && opL_q == OP_WR_EN) begin
			writeEnableLatch <= 1'b1;
		end else if (frameEnd && state_q == ST_IDLE && good_q && opL_q == OP_WR_DIS) begin
			writeEnableLatch <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Core side: protection state, changed when the operation ends
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			volatileProtectBit <= PROT_RESET;
			persistentProtectBit <= PROT_RESET;
			protectConfigRegister <= CFG_RESET;
			protectLockRegister <= LOCK_RESET;
		end else if (done) begin
			case (job_q)
				JOB_VOL: volatileProtectBit[jobSect_q] <= jobData_q[7:0] == ACCESS_OPEN;
				JOB_PG: persistentProtectBit[jobSect_q] <= 1'b0;
				JOB_ER: persistentProtectBit <= PROT_RESET;
				JOB_CFG: protectConfigRegister <= {jobData_q[7:0], jobData_q[15:8]};
				JOB_LOCK: protectLockRegister[LOCK_BIT] <= 1'b0;
				JOB_FRZ: protectLockRegister[FREEZE_BIT] <= 1'b1;
				default: protectLockRegister <= protectLockRegister;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_wel_gate: assert property (@(posedge clock) disable iff (srst)
		$rose(writeInProgress) |-> $past(writeEnableLatch))
		else $error("Operation started without write enable latch");

	chk_ignore_nowel: assert property (@(posedge clock) disable iff (srst)
		(frameEnd && needsWel && !writeEnableLatch && !writeInProgress) |=>
		(!writeInProgress && $stable(persistentProtectBit) && $stable(volatileProtectBit)
		&& $stable(protectConfigRegister) && $stable(protectLockRegister)))
		else $error("Protected command acted without latch");

	chk_busy_span: assert property (@(posedge clock) disable iff (srst)
		($rose(writeInProgress) && job_q != JOB_ER) |-> writeInProgress [*8] ##(BusyCycles - 7) !writeInProgress)
		else $error("Program busy time wrong");

	chk_erase_span: assert property (@(posedge clock) disable iff (srst)
		($rose(writeInProgress) && job_q == JOB_ER) |-> ##(EraseCycles - 1) writeInProgress ##1 !writeInProgress)
		else $error("Erase busy time wrong");

	chk_wel_clear: assert property (@(posedge clock) disable iff (srst)
		$fell(writeInProgress) |-> !writeEnableLatch)
		else $error("Latch not cleared at end");

	chk_erase_all: assert property (@(posedge clock) disable iff (srst)
		(done && job_q == JOB_ER) |=> &persistentProtectBit)
		else $error("Erase left a persistent bit at zero");

	chk_freeze_set: assert property (@(posedge clock) disable iff (srst)
		(done && job_q == JOB_FRZ) |=> protectLockRegister[FREEZE_BIT] && $stable(protectLockRegister[LOCK_BIT]))
		else $error("Freeze bit not set");

	chk_lock_clear: assert property (@(posedge clock) disable iff (srst)
		(done && job_q == JOB_LOCK) |=> !protectLockRegister[LOCK_BIT])
		else $error("Lock bit not cleared");

	chk_cfg_order: assert property (@(posedge clock) disable iff (srst)
		(done && job_q == JOB_CFG) |=> protectConfigRegister == {$past(jobData_q[7:0]), $past(jobData_q[15:8])})
		else $error("Config bytes in wrong order");

	chk_quad_quiet: assert property (@(negedge sck) disable iff (csN)
		(quadSync_q && (opL_q == OP_PERS_RD || opL_q == OP_PERS_RD_LONG)) |=> !soOe)
		else $error("Persistent read answered in quad mode");

	chk_lock_idle: assert property (@(negedge sck) disable iff (csN)
		(wipSync_q && opL_q == OP_LOCK_RD) |=> !soOe)
		else $error("Lock read answered while busy");

endmodule

// ---- verif/fsp_host_model.sv ----
// Host controller model for the sector protection command logic.
// Assumes the device drives so on the falling serial clock edge.
`timescale 1ns/1ns
module fsp_host_model (
	// Serial link
	output logic sck,
	output logic csN,
	output logic si,
	input wire logic so,
	input wire logic soOe
);
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		si = 1'b0;
	end

	// ----------------------------------------------------------------
	// Frame
	// ----------------------------------------------------------------
	// Clock runs only inside the frame; data flips after release so a stale level never looks valid
	task automatic frame(input logic [63:0] hdr, input int nh, input int nr, output logic [31:0] rd,
			output logic oe);
		rd = '0;
		oe = 1'b1;
		csN = 1'b0;
		#20;
		for (int i = nh - 1; i >= 0; i--) begin
			si = hdr[i];
			#16 sck = 1'b1;
			#16 sck = 1'b0;
		end
		for (int i = 0; i < nr; i++) begin
			#16 sck = 1'b1;
			rd = {rd[30:0], so};
			oe = oe & soOe;
			#16 sck = 1'b0;
		end
		#16 csN = 1'b1;
		si = ~si;
		#200;
	endtask
endmodule

// ---- verif/fsp_protect_cmds_tb.sv ----
// Self-checking bench for the sector protection command logic.
// Assumes the host model in fsp_host_model.sv and the shared package.
`timescale 1ns/1ns
module fsp_protect_cmds_tb;
	import fsp_pkg::*;
	logic clock, srst, sck, csN, si, so, soOe, quadWideCmdMode, writeEnableLatch, writeInProgress, oe;
	logic [7:0] bankAddr, protectLockRegister;
	logic [SECTORS-1:0] volatileProtectBit, persistentProtectBit, expV, expP;
	logic [15:0] protectConfigRegister;
	logic [31:0] rd;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;

	fsp_protect_cmds fsp_protect_cmds_i (.clock(clock), .srst(srst), .sck(sck), .csN(csN), .si(si), .so(so),
		.soOe(soOe), .bankAddr(bankAddr), .quadWideCmdMode(quadWideCmdMode),
		.volatileProtectBit(volatileProtectBit), .persistentProtectBit(persistentProtectBit),
		.protectConfigRegister(protectConfigRegister), .protectLockRegister(protectLockRegister),
		.writeEnableLatch(writeEnableLatch), .writeInProgress(writeInProgress));
	fsp_host_model fsp_host_model_i (.sck(sck), .csN(csN), .si(si), .so(so), .soOe(soOe));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (n_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic tx(input logic [63:0] h, input int nh, input int nr);
		fsp_host_model_i.frame(h, nh, nr, rd, oe);
	endtask

	// Command, then a status poll in mid-operation, then a bounded wait for idle
	task automatic op(input logic [63:0] h, input int nh, input logic busy);
		tx(h, nh, 0);
		tx(OP_STAT_RD, 8, 8);
		chk(rd[0], busy);
		// Poll away from the core edge so the outputs are settled when read
		for (int i = 0; i < 100 && writeInProgress !== 1'b0; i++) @(negedge clock);
		chk(writeInProgress, 1'b0);
		if (busy) chk(writeEnableLatch, 1'b0);
	endtask

	task automatic write_enable_cmd();
		tx(OP_WR_EN, 8, 0);
	endtask

	task automatic ext(input logic on);
		@(negedge clock);
		bankAddr = {on, 7'h00};
	endtask

	// ----------------------------------------------------------------
	// Clock and timeout
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Whole run needs about 1300 cycles; a hang ends here
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		bankAddr = 8'h00;
		quadWideCmdMode = 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock) srst = 1'b0;
		repeat (5) @(negedge clock);
		expV = PROT_RESET;
		expP = PROT_RESET;
		chk({writeEnableLatch, writeInProgress, protectConfigRegister, protectLockRegister},
			{2'b00, CFG_RESET, LOCK_RESET});
		chk(persistentProtectBit, PROT_RESET);
		// Volatile writes: refused without latch, then 3-byte, 4-byte and long forms
		op({OP_VOL_WR, 24'h050000, 8'h00}, 40, 1'b0);
		chk(volatileProtectBit, expV);
		write_enable_cmd();
		op({OP_VOL_WR, 24'h050000, 8'h00}, 40, 1'b1);
		ext(1'b1);
		write_enable_cmd();
		op({OP_VOL_WR, 32'h00060000, 8'h00}, 48, 1'b1);
		ext(1'b0);
		write_enable_cmd();
		op({OP_VOL_WR_LONG, 32'h00070000, 8'h00}, 48, 1'b1);
		expV[7:5] = 3'b000;
		chk(volatileProtectBit, expV);
		write_enable_cmd();
		op({OP_VOL_WR, 24'h080000, 9'h000}, 41, 1'b0);
		chk({writeEnableLatch, volatileProtectBit}, {1'b1, expV});
		// Persistent program in all address forms
		op({OP_PERS_PG, 24'h030000}, 32, 1'b1);
		ext(1'b1);
		write_enable_cmd();
		op({OP_PERS_PG, 32'h00040000}, 40, 1'b1);
		ext(1'b0);
		write_enable_cmd();
		op({OP_PERS_PG_LONG, 32'h00090000}, 40, 1'b1);
		expP[3] = 1'b0;
		expP[4] = 1'b0;
		expP[9] = 1'b0;
		chk(persistentProtectBit, expP);
		// Persistent reads repeat one byte; none in quad mode
		tx({OP_PERS_RD, 24'h030000}, 32, 16);
		chk({oe, rd[15:0]}, {1'b1, ACCESS_SHUT, ACCESS_SHUT});
		tx({OP_PERS_RD, 24'h050000}, 32, 16);
		chk({oe, rd[15:0]}, {1'b1, ACCESS_OPEN, ACCESS_OPEN});
		tx({OP_PERS_RD_LONG, 32'h00090000}, 40, 8);
		chk(rd[7:0], ACCESS_SHUT);
		ext(1'b1);
		tx({OP_PERS_RD, 32'h00040000}, 40, 8);
		chk(rd[7:0], ACCESS_SHUT);
		ext(1'b0);
		@(negedge clock) quadWideCmdMode = 1'b1;
		tx({OP_PERS_RD, 24'h030000}, 32, 8);
		chk(oe, 1'b0);
		@(negedge clock) quadWideCmdMode = 1'b0;
		// Erase: a long frame is dropped, an exact one restores all bits
		write_enable_cmd();
		op({OP_PERS_ER, 1'b0}, 9, 1'b0);
		chk(persistentProtectBit, expP);
		op(OP_PERS_ER, 8, 1'b1);
		chk(persistentProtectBit, PROT_RESET);
		// Config register: short frame dropped, then program and repeating read
		write_enable_cmd();
		op({OP_CFG_PG, 15'h1a09}, 23, 1'b0);
		chk(protectConfigRegister, CFG_RESET);
		op({OP_CFG_PG, 8'h34, 8'h12}, 24, 1'b1);
		chk(protectConfigRegister, 16'h1234);
		tx(OP_CFG_RD, 8, 32);
		chk(rd, 32'h34123412);
		// Lock register: clear, freeze, read when idle and while busy
		write_enable_cmd();
		op(OP_LOCK_CLR, 8, 1'b1);
		chk(protectLockRegister, 8'h00);
		op(OP_FREEZE, 8, 1'b0);
		chk(protectLockRegister, 8'h00);
		write_enable_cmd();
		op(OP_FREEZE, 8, 1'b1);
		chk(protectLockRegister, 8'h80);
		tx(OP_LOCK_RD, 8, 16);
		chk({oe, rd[15:0]}, {1'b1, 16'h8080});
		write_enable_cmd();
		tx(OP_FREEZE, 8, 0);
		tx(OP_LOCK_RD, 8, 8);
		chk(oe, 1'b0);
		for (int i = 0; i < 100 && writeInProgress !== 1'b0; i++) @(negedge clock);
		chk(writeInProgress, 1'b0);
		// Latch shows in status, then write disable drops it
		write_enable_cmd();
		tx(OP_STAT_RD, 8, 8);
		chk(rd[1:0], 2'b10);
		tx(OP_WR_DIS, 8, 0);
		tx(OP_STAT_RD, 8, 8);
		chk({writeEnableLatch, rd[1:0]}, 3'b000);
		complete_run();
	end
endmodule
